// ===== src/io_expander_pkg.sv
package io_expander_pkg;

  // Pins of the largest variant, eight per port
  localparam int NPIN = 64;
  // Bits in one serial byte
  localparam logic [3:0] BITS = 4'h8;
  // Fixed upper part of the port device slave address
  localparam logic [6:0] SLAVE_BASE = 7'h20;

  // Command byte map
  localparam logic [7:0] R_INPUT = 8'h00;
  localparam logic [7:0] R_OUTPUT = 8'h08;
  localparam logic [7:0] R_FLAGS = 8'h10;
  localparam logic [7:0] R_PORT_SEL = 8'h18;
  localparam logic [7:0] R_MASK = 8'h19;
  localparam logic [7:0] R_PWM_SEL = 8'h1a;
  localparam logic [7:0] R_INVERT = 8'h1b;
  localparam logic [7:0] R_MODE = 8'h1c;
  localparam logic [7:0] R_ADDR_CFG = 8'h23;

  // Drive mode codes, one per pin
  localparam logic [2:0] MODE_PULL_UP = 3'h0;
  localparam logic [2:0] MODE_PULL_DN = 3'h1;
  localparam logic [2:0] MODE_OD_HI = 3'h2;
  localparam logic [2:0] MODE_OD_LO = 3'h3;
  localparam logic [2:0] MODE_STRONG = 3'h4;
  localparam logic [2:0] MODE_SLOW = 3'h5;
  localparam logic [2:0] MODE_HIZ = 3'h6;

  // Reset values
  localparam logic [2:0] MODE_RST = MODE_PULL_UP;
  localparam logic [63:0] OUT_RST = 64'hffff_ffff_ffff_ffff;
  localparam logic [63:0] MASK_RST = 64'hffff_ffff_ffff_ffff;

  // Bonded pins: port 2 has only its low four bits
  localparam logic [63:0] PIN_PRESENT = 64'hffff_ffff_ff0f_ffff;

  // Shared pins: extra address inputs, then write block input
  localparam logic [2:0] ADDR_N_MAX = 3'h6;
  localparam logic [5:0][5:0] ADDR_PIN =
    {6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12, 6'h13};
  localparam logic [5:0] WD_PIN = 6'h0d;

  // Serial slave states
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_ADDR = 6'h02,
    S_ACK = 6'h04,
    S_RX = 6'h08,
    S_TX = 6'h10,
    S_TXACK = 6'h20
  } i2c_state_t;

  // Per-pin drive controls
  typedef struct packed {
    logic [63:0] o;
    logic [63:0] oe;
    logic [63:0] pu;
    logic [63:0] pd;
    logic [63:0] slow;
  } pin_drive_t;

  // Whole state of the port logic
  typedef struct packed {
    logic scl_m;
    logic scl_r;
    logic scl_p;
    logic sda_m;
    logic sda_r;
    logic sda_p;
    logic a0_m;
    logic a0_r;
    logic [63:0] in_m;
    logic [63:0] in_r;
    logic [63:0] in_p;
    logic [15:0] pwm_p;
    i2c_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic cmd_ph;
    logic nack;
    logic sda_oe;
    logic [2:0] sel;
    logic [63:0] outv;
    logic [63:0] inv;
    logic [63:0] pwm;
    logic [63:0] mask;
    logic [63:0] flags;
    logic [63:0][2:0] mode;
    logic [2:0] addr_n;
    logic wd_en;
    pin_drive_t pin;
    logic irq;
    logic wblk;
  } port_state_t;

endpackage

// ===== src/io_expander_port_logic.sv
`timescale 1ns/100ps
// Overview of operation
// [RQ1] Output latch bits drive pins per mode
// [RQ2] Input read returns sampled pin levels
// [RQ3] Output and input storage kept separate
// [RQ4] Seven drive modes selectable per pin
// [RQ5] Reset selects pulled-up mode everywhere
// [RQ6] Invert bit flips reported input value
// [RQ7] PWM select routes generator to pin
// [RQ8] Level change since read sets flag
// [RQ9] Reading flags register clears it
// [RQ10] Mask bit blocks change from interrupt
// [RQ11] Interrupt on unmasked change or PWM toggle
// [RQ12] Shared pins become address or write-block
// [RQ13] Unassigned shared pins stay ordinary IO
// [RQ14] Stored defaults replayed after power-on
// [RQ15] One slave address reaches all registers
// [RQ16] Sixteen 8-bit PWM generators feed pins
// [RQ17] Port widths follow the largest variant
// [RQ18] Host sends command byte first
// [RQ19] Pins synchronised, compared with last sample
// [RQ20] Interrupt held while unmasked flag set
module io_expander_port_logic (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Serial link pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Fixed address pin
  input wire logic fixed_slave_addr_pin,
  // Port pins
  input wire logic [63:0] gpio_bank_i,
  output logic [63:0] gpio_bank_o,
  output logic [63:0] gpio_bank_oe,
  output logic [63:0] gpio_bank_pu,
  output logic [63:0] gpio_bank_pd,
  output logic [63:0] gpio_bank_slow,
  // PWM generator outputs
  input wire logic [15:0] pwm_in,
  // Stored defaults replay
  input wire logic nv_we,
  input wire logic [7:0] nv_cmd,
  input wire logic [7:0] nv_data,
  // Host interrupt and write block
  output logic irq,
  output logic eeprom_wr_block
);

  io_expander_pkg::port_state_t q, d; // State and its next value
  logic rise, fall, start, stop; // Link events
  logic rd_go; // Load next read byte
  logic [7:0] rb; // Byte read out
  logic [63:0] chg, pwm_edge, set_v, rsv; // Per-pin events
  logic [63:0] dr_o, dr_oe, dr_pu, dr_pd, dr_sl; // Drive controls
  logic [6:0] my_addr; // Address this device answers to

  ////////////////////////////////////////////////////////////////////////
  // Register write, shared by host and defaults replay
  function automatic io_expander_pkg::port_state_t wr_reg(
    input io_expander_pkg::port_state_t s,
    input logic [7:0] a,
    input logic [7:0] v);
    io_expander_pkg::port_state_t r;
    logic [5:0] b;
    r = s;
    b = {s.sel, 3'h0};
    if (a >= io_expander_pkg::R_OUTPUT && a < io_expander_pkg::R_FLAGS)
      r.outv[{a[2:0], 3'h0} +: 8] = v; // RQ1
    else if (a == io_expander_pkg::R_PORT_SEL)
      r.sel = v[2:0];
    else if (a == io_expander_pkg::R_MASK)
      r.mask[b +: 8] = v;
    else if (a == io_expander_pkg::R_PWM_SEL)
      r.pwm[b +: 8] = v;
    else if (a == io_expander_pkg::R_INVERT)
      r.inv[b +: 8] = v;
    else if (a >= io_expander_pkg::R_MODE &&
             a < io_expander_pkg::R_ADDR_CFG) begin
      // A one moves that pin to this mode; zeros leave pins alone
      for (int i = 0; i < 8; i++)
        if (v[i])
          r.mode[b + 6'(i)] = 3'(a - io_expander_pkg::R_MODE); // RQ4
    end else if (a == io_expander_pkg::R_ADDR_CFG) begin
      r.addr_n = (v[2:0] > io_expander_pkg::ADDR_N_MAX) ?
                 io_expander_pkg::ADDR_N_MAX : v[2:0]; // RQ12
      r.wd_en = v[3];
    end
    return r;
  endfunction

  // Register read; unmapped commands read as zero
  function automatic logic [7:0] rd_reg(
    input io_expander_pkg::port_state_t s,
    input logic [7:0] a);
    logic [63:0] lv;
    logic [7:0] r;
    logic [5:0] b;
    lv = (s.in_r ^ s.inv) & io_expander_pkg::PIN_PRESENT; // RQ2 RQ6
    r = 8'h00;
    b = {s.sel, 3'h0};
    if (a < io_expander_pkg::R_OUTPUT)
      r = lv[{a[2:0], 3'h0} +: 8];
    else if (a < io_expander_pkg::R_FLAGS)
      r = s.outv[{a[2:0], 3'h0} +: 8]; // RQ3
    else if (a < io_expander_pkg::R_PORT_SEL)
      r = s.flags[{a[2:0], 3'h0} +: 8];
    else if (a == io_expander_pkg::R_PORT_SEL)
      r = {5'h00, s.sel};
    else if (a == io_expander_pkg::R_MASK)
      r = s.mask[b +: 8];
    else if (a == io_expander_pkg::R_PWM_SEL)
      r = s.pwm[b +: 8];
    else if (a == io_expander_pkg::R_INVERT)
      r = s.inv[b +: 8];
    else if (a < io_expander_pkg::R_ADDR_CFG) begin
      for (int i = 0; i < 8; i++)
        r[i] = s.mode[b + 6'(i)] == 3'(a - io_expander_pkg::R_MODE);
    end else if (a == io_expander_pkg::R_ADDR_CFG)
      r = {4'h0, s.wd_en, s.addr_n};
    return r;
  endfunction

  // Pins taken over as address or write-block inputs
  function automatic logic [63:0] rsv_mask(
    input io_expander_pkg::port_state_t s);
    logic [63:0] m;
    m = '0;
    for (int i = 0; i < 6; i++)
      if (3'(i) < s.addr_n)
        m[io_expander_pkg::ADDR_PIN[i]] = 1'b1; // RQ12 RQ13
    if (s.wd_en)
      m[io_expander_pkg::WD_PIN] = 1'b1;
    return m;
  endfunction

  // Slave address: low bits replaced by the fixed address pin and the enabled address pins
  function automatic logic [6:0] slave_addr(
    input io_expander_pkg::port_state_t s);
    logic [6:0] ab, am;
    ab = {6'h00, s.a0_r};
    am = ~(7'h7e << s.addr_n);
    for (int i = 0; i < 6; i++)
      ab[i + 1] = s.in_r[io_expander_pkg::ADDR_PIN[i]];
    return (io_expander_pkg::SLAVE_BASE & ~am) | (ab & am); // RQ15
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Link events from synchronised samples, clock sampled not used
  assign rise = q.scl_r & ~q.scl_p;
  assign fall = ~q.scl_r & q.scl_p;
  assign start = q.scl_r & q.scl_p & q.sda_p & ~q.sda_r;
  assign stop = q.scl_r & q.scl_p & ~q.sda_p & q.sda_r;
  assign my_addr = slave_addr(q);
  assign rsv = rsv_mask(q);
  // Change against the previous sample, per pin
  assign chg = q.in_r ^ q.in_p; // RQ19
  assign set_v = (chg | pwm_edge) & io_expander_pkg::PIN_PRESENT & ~rsv;

  ////////////////////////////////////////////////////////////////////////
  // Per-pin drive: value, mode and PWM routing
  for (genvar p = 0; p < io_expander_pkg::NPIN; p++) begin : g_pin
    logic v; // Value the pin should show
    logic [2:0] m; // Effective mode
    // Generator p mod 16 serves this pin
    assign v = q.pwm[p] ? pwm_in[p % 16] : q.outv[p]; // RQ7 RQ16
    // Absent pins and shared pins taken over as inputs are never driven
    assign m = (rsv[p] | ~io_expander_pkg::PIN_PRESENT[p]) ?
               io_expander_pkg::MODE_HIZ : q.mode[p]; // RQ13 RQ17
    assign dr_o[p] = v; // RQ1
    assign dr_oe[p] = (m == io_expander_pkg::MODE_PULL_UP & ~v) |
                      (m == io_expander_pkg::MODE_PULL_DN & v) |
                      (m == io_expander_pkg::MODE_OD_HI & v) |
                      (m == io_expander_pkg::MODE_OD_LO & ~v) |
                      (m == io_expander_pkg::MODE_STRONG) |
                      (m == io_expander_pkg::MODE_SLOW); // RQ4
    assign dr_pu[p] = m == io_expander_pkg::MODE_PULL_UP; // RQ4 RQ5
    assign dr_pd[p] = m == io_expander_pkg::MODE_PULL_DN;
    assign dr_sl[p] = m == io_expander_pkg::MODE_SLOW;
    // Routed generator toggled
    assign pwm_edge[p] = q.pwm[p] &
                         (pwm_in[p % 16] ^ q.pwm_p[p % 16]); // RQ11
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;
    rd_go = 1'b0;
    rb = 8'h00;
    // Two flops on link, address and port inputs, third for edges; pwm_in gets one flop
    d.scl_m = scl_i;
    d.scl_r = q.scl_m;
    d.scl_p = q.scl_r;
    d.sda_m = sda_i;
    d.sda_r = q.sda_m;
    d.sda_p = q.sda_r;
    d.a0_m = fixed_slave_addr_pin;
    d.a0_r = q.a0_m;
    d.in_m = gpio_bank_i; // RQ19
    d.in_r = q.in_m;
    d.in_p = q.in_r;
    d.pwm_p = pwm_in;
    // Replay of stored defaults; host writes below take precedence
    if (nv_we)
      d = wr_reg(d, nv_cmd, nv_data); // RQ14
    if (start) begin
      d.st = io_expander_pkg::S_ADDR;
      d.cnt = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop) begin
      d.st = io_expander_pkg::S_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        // Waiting for a start
        io_expander_pkg::S_IDLE: begin
        end
        // Shift in address, command or data
        io_expander_pkg::S_ADDR, io_expander_pkg::S_RX: begin
          if (rise) begin
            d.sh = {q.sh[6:0], q.sda_r};
            d.cnt = q.cnt + 4'h1;
          end else if (fall && q.cnt == io_expander_pkg::BITS) begin
            d.cnt = 4'h0;
            if (q.st == io_expander_pkg::S_ADDR) begin
              if (q.sh[7:1] == my_addr) begin
                d.st = io_expander_pkg::S_ACK; // RQ15
                d.sda_oe = 1'b1;
                d.rw = q.sh[0];
                d.cmd_ph = ~q.sh[0];
              end else begin
                d.st = io_expander_pkg::S_IDLE;
              end
            end else begin
              d.st = io_expander_pkg::S_ACK;
              d.sda_oe = 1'b1;
              if (q.cmd_ph) begin
                // First byte of a write is the pointer
                d.ptr = q.sh; // RQ18
                d.cmd_ph = 1'b0;
              end else begin
                d = wr_reg(d, q.ptr, q.sh); // RQ15
                d.ptr = q.ptr + 8'h01;
              end
            end
          end
        end
        // Our acknowledge bit
        io_expander_pkg::S_ACK: begin
          if (fall) begin
            d.sda_oe = 1'b0;
            if (q.rw)
              rd_go = 1'b1;
            else
              d.st = io_expander_pkg::S_RX;
          end
        end
        // Shift out, MSB first, changing on the falling edge
        io_expander_pkg::S_TX: begin
          if (fall) begin
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == 4'h7) begin
              d.sda_oe = 1'b0;
              d.st = io_expander_pkg::S_TXACK;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.sda_oe = ~q.sh[6];
            end
          end
        end
        // Host acknowledge; a nack ends the read
        io_expander_pkg::S_TXACK: begin
          if (rise)
            d.nack = q.sda_r;
          else if (fall) begin
            if (q.nack)
              d.st = io_expander_pkg::S_IDLE;
            else
              rd_go = 1'b1;
          end
        end
        default: d.st = io_expander_pkg::S_IDLE;
      endcase
    end
    // Fetch a byte; pins are sampled now, at read time
    if (rd_go) begin
      rb = rd_reg(q, q.ptr); // RQ2
      d.sh = rb;
      d.sda_oe = ~rb[7];
      d.cnt = 4'h0;
      d.st = io_expander_pkg::S_TX;
      d.ptr = q.ptr + 8'h01;
      if (q.ptr >= io_expander_pkg::R_FLAGS &&
          q.ptr < io_expander_pkg::R_PORT_SEL)
        d.flags[{q.ptr[2:0], 3'h0} +: 8] = 8'h00; // RQ9
    end
    // Set after clear, so a change in the read cycle survives
    d.flags = d.flags | set_v; // RQ8 RQ11
    d.pin = {dr_o, dr_oe, dr_pu, dr_pd, dr_sl};
    d.irq = |(d.flags & ~d.mask); // RQ10 RQ20
    d.wblk = q.wd_en & q.in_r[io_expander_pkg::WD_PIN]; // RQ12
  end

  // State register; reset gives pull-ups on every bonded pin
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.st <= io_expander_pkg::S_IDLE;
      q.mode <= {io_expander_pkg::NPIN{io_expander_pkg::MODE_RST}}; // RQ5
      q.outv <= io_expander_pkg::OUT_RST;
      q.mask <= io_expander_pkg::MASK_RST;
      q.pin.pu <= io_expander_pkg::PIN_PRESENT;
      // Samplers start at the idle high of pulled pins and link lines,
      // so leaving reset shows no false edge and sets no false flag
      {q.scl_m, q.scl_r, q.scl_p, q.sda_m, q.sda_r, q.sda_p} <= 6'h3f;
      q.in_m <= '1;
      q.in_r <= '1;
      q.in_p <= '1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state; sda_o tied low
  assign sda_o = 1'b0;
  assign sda_oe = q.sda_oe;
  assign gpio_bank_o = q.pin.o;
  assign gpio_bank_oe = q.pin.oe;
  assign gpio_bank_pu = q.pin.pu;
  assign gpio_bank_pd = q.pin.pd;
  assign gpio_bank_slow = q.pin.slow;
  assign irq = q.irq;
  assign eeprom_wr_block = q.wblk;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence addr_hit;
    q.st == io_expander_pkg::S_ADDR && fall && !start && !stop &&
      q.cnt == io_expander_pkg::BITS && q.sh[7:1] == my_addr;
  endsequence
  sequence ack_low;
    q.st == io_expander_pkg::S_ACK && q.sda_oe;
  endsequence

  addr_ack_a: assert property (addr_hit |=> ack_low) // RQ15
    else $error("Own address not acknowledged");
  flag_set_a: assert property ((|set_v) |=> // RQ8
    (q.flags & $past(set_v)) == $past(set_v))
    else $error("Change did not set its flag");
  flag_clr_a: assert property (rd_go && // RQ9
    q.ptr == io_expander_pkg::R_FLAGS && set_v[7:0] == 8'h00
    |=> q.flags[7:0] == 8'h00)
    else $error("Flags not cleared by read");
  irq_tie_a: assert property (q.irq == |(q.flags & ~q.mask)) // RQ10 RQ20
    else $error("Interrupt disagrees with flags and mask");
  input_read_a: assert property (rd_go && // RQ2 RQ6
    q.ptr == io_expander_pkg::R_INPUT
    |=> q.sh == $past(q.in_r[7:0] ^ q.inv[7:0]))
    else $error("Input read not from pins");
  pull_drive_a: assert property ( // RQ4 RQ5
    q.mode[0] == io_expander_pkg::MODE_PULL_UP && !q.pwm[0]
    |=> q.pin.pu[0] && q.pin.oe[0] == !$past(q.outv[0]))
    else $error("Pulled-up pin drive wrong");
  strong_drive_a: assert property ( // RQ1
    q.mode[0] == io_expander_pkg::MODE_STRONG && !q.pwm[0]
    |=> q.pin.oe[0] && q.pin.o[0] == $past(q.outv[0]))
    else $error("Strong pin not showing output latch");
  pwm_route_a: assert property ( // RQ7
    q.pwm[0] && q.mode[0] == io_expander_pkg::MODE_STRONG
    |=> q.pin.o[0] == $past(pwm_in[0]))
    else $error("PWM not routed to pin");
  addr_pin_a: assert property (q.addr_n != 3'h0 |=> // RQ12
    !q.pin.oe[io_expander_pkg::ADDR_PIN[0]])
    else $error("Address pin driven");

endmodule

// ===== dv/i2c_host_model.sv
`timescale 1ns/100ps
// Host on the serial link; clock driven high at idle, data released (pulled high)
module i2c_host_model (
  // Link lines
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // Clock rests high between frames, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // Start or repeated start: data falls while clock is high
  task automatic start();
    #31 sda_low = 1'b0;
    #31.5 scl = 1'b1;
    #62.5 sda_low = 1'b1;
    #62.5 scl = 1'b0;
  endtask
  // One 125 ns clock pulse; data moves only while clock is low
  task automatic bit_cyc(input logic b, output logic r);
    #31 sda_low = ~b;
    #31.5 scl = 1'b1;
    #31 r = sda;
    #31.5 scl = 1'b0;
  endtask
  // Byte out MSB first, then the device acknowledge slot
  task automatic wr_byte(input logic [7:0] v, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(v[i], r);
    end
    bit_cyc(1'b1, nack);
  endtask
  // Byte in; refusing the last byte ends the read
  task automatic rd_byte(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(1'b1, v[i]);
    end
    // Acknowledge slot; its own level is not part of the byte
    bit_cyc(last, r);
  endtask
  // Stop: data rises while clock is high, then all released
  task automatic stop();
    #31 sda_low = 1'b1;
    #31.5 scl = 1'b1;
    #62.5 sda_low = 1'b0;
  endtask
endmodule

// ===== dv/io_expander_port_logic_tb_top.sv
`timescale 1ns/100ps
// Bench: host model on the link, reference registers in the bench
module io_expander_port_logic_tb_top;
  // Clock, reset, counters
  logic clock;
  logic rst;
  int checks;
  int n_mismatch;
  int cycles;
  // Design pins
  logic scl, sda_low, sda_oe, sda_o, fixed_slave_addr_pin, irq, wblk;
  logic [63:0] gpio_in, g_o, g_oe, g_pu, g_pd, g_slow;
  logic [15:0] pwm_in;
  logic nv_we;
  logic [7:0] nv_cmd, nv_data;
  // Reference model of the register file
  logic [63:0] m_out, m_inv, m_mask, m_pwm;
  logic [2:0] m_sel;
  int m_mode[64];
  logic [6:0] dev;
  logic nk;
  logic [7:0] d;
  // Open-drain data line with pull-up
  wire sda = ~(sda_low | (sda_oe & ~sda_o));

  io_expander_port_logic i_dut (.clock(clock), .rst(rst), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .fixed_slave_addr_pin(fixed_slave_addr_pin), .gpio_bank_i(gpio_in),
    .gpio_bank_o(g_o), .gpio_bank_oe(g_oe), .gpio_bank_pu(g_pu),
    .gpio_bank_pd(g_pd), .gpio_bank_slow(g_slow), .pwm_in(pwm_in),
    .nv_we(nv_we), .nv_cmd(nv_cmd), .nv_data(nv_data), .irq(irq),
    .eeprom_wr_block(wblk));
  i2c_host_model h (.scl(scl), .sda_low(sda_low), .sda(sda));

  // 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Hang guard, well above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [63:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Reference update for one register write
  task automatic model_wr(input logic [7:0] c, v);
    if (c[7:3] == 5'h01) m_out[c[2:0]*8 +: 8] = v;
    else if (c == io_expander_pkg::R_PORT_SEL) m_sel = v[2:0];
    else if (c == io_expander_pkg::R_MASK) m_mask[m_sel*8 +: 8] = v;
    else if (c == io_expander_pkg::R_PWM_SEL) m_pwm[m_sel*8 +: 8] = v;
    else if (c == io_expander_pkg::R_INVERT) m_inv[m_sel*8 +: 8] = v;
    else if (c >= io_expander_pkg::R_MODE && c < io_expander_pkg::R_ADDR_CFG)
      for (int i = 0; i < 8; i++) begin
        if (v[i]) m_mode[m_sel*8+i] = c - io_expander_pkg::R_MODE;
      end
  endtask
  // Expected read value from the reference
  function automatic logic [7:0] exp_rd(input logic [7:0] c);
    logic [7:0] e;
    e = 8'h00;
    if (c[7:3] == 5'h00) e = gpio_in[c[2:0]*8 +: 8] ^ m_inv[c[2:0]*8 +: 8];
    else if (c[7:3] == 5'h01) e = m_out[c[2:0]*8 +: 8];
    else if (c == io_expander_pkg::R_PWM_SEL) e = m_pwm[m_sel*8 +: 8];
    else if (c == io_expander_pkg::R_INVERT) e = m_inv[m_sel*8 +: 8];
    else if (c >= io_expander_pkg::R_MODE && c < io_expander_pkg::R_ADDR_CFG)
      for (int i = 0; i < 8; i++) begin
        e[i] = (m_mode[m_sel*8+i] == c - io_expander_pkg::R_MODE);
      end
    return e;
  endfunction
  // Register write: address, command byte, value
  task automatic reg_wr(input logic [7:0] c, v);
    logic n1, n2, n3;
    h.start();
    h.wr_byte({dev, 1'b0}, n1);
    h.wr_byte(c, n2);
    h.wr_byte(v, n3);
    h.stop();
    check("write ack", {n1, n2, n3}, 3'h0);
    model_wr(c, v);
    wait_clk(4);
  endtask
  // Register read: point with a write, then repeated start and read
  task automatic reg_rd(input logic [7:0] c, output logic [7:0] v);
    logic n1, n2, n3;
    h.start();
    h.wr_byte({dev, 1'b0}, n1);
    h.wr_byte(c, n2);
    h.start();
    h.wr_byte({dev, 1'b1}, n3);
    h.rd_byte(1'b1, v);
    h.stop();
    check("read ack", {n1, n2, n3}, 3'h0);
    wait_clk(4);
  endtask
  task automatic rd_chk(input logic [7:0] c);
    logic [7:0] v;
    reg_rd(c, v);
    check("register read", v, exp_rd(c));
  endtask
  // Toggle one pin and let synchronisers and flags settle
  task automatic pin_flip(input int p);
    @(posedge clock);
    #1 gpio_in[p] = ~gpio_in[p];
    wait_clk(10);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    gpio_in = '1;
    pwm_in = 16'h0;
    nv_we = 1'b0;
    nv_cmd = 8'h00;
    nv_data = 8'h00;
    fixed_slave_addr_pin = 1'b1;
    m_out = io_expander_pkg::OUT_RST;
    m_mask = io_expander_pkg::MASK_RST;
    m_inv = 64'h0;
    m_pwm = 64'h0;
    m_sel = 3'h0;
    foreach (m_mode[i]) m_mode[i] = 0;
    dev = {io_expander_pkg::SLAVE_BASE[6:1], 1'b1};
    void'($urandom(47));
    repeat (4) @(posedge clock);
    #1 rst = 1'b0;
    check("pull-ups", g_pu, io_expander_pkg::PIN_PRESENT);
    check("drive enables", g_oe, 64'h0);
    check("irq idle", irq, 1'b0);
    rd_chk(io_expander_pkg::R_MODE);
    rd_chk(io_expander_pkg::R_OUTPUT + 8'h01);
    $display("test reset done");
    // Pin k of port 0 set to mode k
    for (int k = 0; k < 7; k++) begin
      reg_wr(io_expander_pkg::R_MODE + k[7:0], 8'h01 << k);
    end
    for (int k = 0; k < 7; k++) rd_chk(io_expander_pkg::R_MODE + k[7:0]);
    check("pulls", {g_pu[7:0], g_pd[7:0], g_slow[7:0]}, 24'h810220);
    check("strong drive", g_oe[6:4], 3'h3);
    $display("test modes done");
    // Output latch reaches the pins under strong drive
    reg_wr(io_expander_pkg::R_MODE + 8'h04, 8'hff);
    d = 8'($urandom);
    reg_wr(io_expander_pkg::R_OUTPUT, d);
    check("port 0 pins", g_o[7:0], d);
    check("port 0 enables", g_oe[7:0], 8'hff);
    rd_chk(io_expander_pkg::R_OUTPUT);
    // Two bytes in one read: host acks the first, pointer steps
    h.start();
    h.wr_byte({dev, 1'b0}, nk);
    h.wr_byte(io_expander_pkg::R_OUTPUT, nk);
    h.start();
    h.wr_byte({dev, 1'b1}, nk);
    h.rd_byte(1'b0, d);
    check("burst 0", d, exp_rd(io_expander_pkg::R_OUTPUT));
    h.rd_byte(1'b1, d);
    h.stop();
    check("burst 1", d, exp_rd(io_expander_pkg::R_OUTPUT + 8'h01));
    wait_clk(4);
    $display("test output done");
    // Input path with inversion, apart from the output latch
    @(posedge clock);
    #1 gpio_in = {$urandom, $urandom};
    reg_wr(io_expander_pkg::R_PORT_SEL, 8'h03);
    reg_wr(io_expander_pkg::R_INVERT, 8'($urandom));
    rd_chk(io_expander_pkg::R_INPUT + 8'h03);
    rd_chk(io_expander_pkg::R_INPUT);
    rd_chk(io_expander_pkg::R_OUTPUT + 8'h03);
    rd_chk(io_expander_pkg::R_INVERT);
    $display("test input done");
    // Change flags, mask and interrupt on port 1
    reg_wr(io_expander_pkg::R_PORT_SEL, 8'h01);
    reg_wr(io_expander_pkg::R_MASK, 8'h00);
    reg_rd(io_expander_pkg::R_FLAGS + 8'h01, d);
    check("irq after clear", irq, 1'b0);
    pin_flip(9);
    check("irq on change", irq, 1'b1);
    reg_rd(io_expander_pkg::R_FLAGS + 8'h01, d);
    check("flags", d, 8'h02);
    reg_rd(io_expander_pkg::R_FLAGS + 8'h01, d);
    check("flags cleared", d, 8'h00);
    check("irq released", irq, 1'b0);
    reg_wr(io_expander_pkg::R_MASK, 8'h02);
    pin_flip(9);
    check("masked irq", irq, 1'b0);
    reg_rd(io_expander_pkg::R_FLAGS + 8'h01, d);
    check("masked flag", d, 8'h02);
    $display("test flags done");
    // Generator routed to pin 0, both edges flagged
    reg_wr(io_expander_pkg::R_PORT_SEL, 8'h00);
    reg_wr(io_expander_pkg::R_PWM_SEL, 8'h01);
    reg_wr(io_expander_pkg::R_MASK, 8'hfe);
    reg_rd(io_expander_pkg::R_FLAGS, d);
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      #1 pwm_in[0] = ~pwm_in[0];
      wait_clk(10);
      check("pwm pin", g_o[0], pwm_in[0]);
      check("pwm irq", irq, 1'b1);
      reg_rd(io_expander_pkg::R_FLAGS, d);
      check("pwm flag", d, 8'h01);
    end
    rd_chk(io_expander_pkg::R_PWM_SEL);
    $display("test pwm done");
    // Replay of one stored default
    @(posedge clock);
    #1 nv_cmd = io_expander_pkg::R_OUTPUT + 8'h05;
    nv_data = 8'($urandom);
    nv_we = 1'b1;
    @(posedge clock);
    #1 nv_we = 1'b0;
    model_wr(nv_cmd, nv_data);
    rd_chk(io_expander_pkg::R_OUTPUT + 8'h05);
    $display("test replay done");
    // One extra address pin plus write block input
    @(posedge clock);
    #1 gpio_in[19] = 1'b1;
    gpio_in[13] = 1'b0;
    reg_wr(io_expander_pkg::R_ADDR_CFG, 8'h09);
    check("block low", wblk, 1'b0);
    pin_flip(13);
    check("block high", wblk, 1'b1);
    h.start();
    h.wr_byte({dev, 1'b0}, nk);
    h.stop();
    check("old address refused", nk, 1'b1);
    dev = {io_expander_pkg::SLAVE_BASE[6:2], 2'h3};
    rd_chk(io_expander_pkg::R_OUTPUT + 8'h05);
    reg_wr(io_expander_pkg::R_ADDR_CFG, 8'h00);
    dev = {io_expander_pkg::SLAVE_BASE[6:1], 1'b1};
    reg_rd(io_expander_pkg::R_INPUT + 8'h02, d);
    check("freed pin", d[3], gpio_in[19] ^ m_inv[19]);
    $display("test address done");
    test_done();
  end
endmodule
